//--- core/lfoc_pkg.sv
// Shared constants for the low-frequency oscillator control block
package lfoc_pkg;
  // Timing
  localparam int unsigned LFOC_CLK_HZ = 200_000_000;
  localparam int unsigned LFOC_NOM_HZ = 80_000;
  localparam int unsigned LFOC_HALF_CYC = LFOC_CLK_HZ / (2 * LFOC_NOM_HZ);
  localparam int unsigned LFOC_TRIM_STEP = 16;
  localparam int unsigned LFOC_TRIM_MID = 8;
  localparam logic [11:0] LFOC_HALF_FAST =
    12'(LFOC_HALF_CYC - LFOC_TRIM_MID * LFOC_TRIM_STEP);
  localparam logic [7:0] LFOC_SETTLE_PER = 8'h04;
  localparam logic [3:0] LFOC_TRIM_RST = 4'h8;
  // Register indices; byte address is four times the index
  localparam logic [9:0] LFOC_CTRL_IDX = 10'h0E3;
  localparam logic [9:0] LFOC_EXT_IDX = 10'h0E4;
  localparam logic [9:0] LFOC_TCFG_IDX = 10'h0E5;
  localparam logic [9:0] LFOC_CAPA_IDX = 10'h0E6;
  localparam logic [9:0] LFOC_CAPB_IDX = 10'h0E7;
  localparam logic [9:0] LFOC_ISTAT_IDX = 10'h0E8;
  localparam logic [9:0] LFOC_IMASK_IDX = 10'h0E9;
  // Field positions
  localparam int unsigned LFOC_EN_BIT = 7;
  localparam int unsigned LFOC_RDY_BIT = 6;
  localparam int unsigned LFOC_TRIM_LSB = 2;
  localparam int unsigned LFOC_DSEL_LSB = 0;
  localparam int unsigned LFOC_XMODE_LSB = 4;
  // Divider select codes
  localparam logic [1:0] LFOC_DIV8 = 2'h0;
  localparam logic [1:0] LFOC_DIV4 = 2'h1;
  localparam logic [1:0] LFOC_DIV2 = 2'h2;
  localparam logic [1:0] LFOC_DIV1 = 2'h3;
  // Upper two bits of the external oscillator mode
  localparam logic [1:0] LFOC_XM_OFF = 2'h0;
  localparam logic [1:0] LFOC_XM_XTAL = 2'h3;
  // Interrupt status bits
  localparam int unsigned LFOC_IRQ_W = 3;
  localparam int unsigned LFOC_IRQ_CAPA = 0;
  localparam int unsigned LFOC_IRQ_CAPB = 1;
  localparam int unsigned LFOC_IRQ_RDY = 2;
  // Bus responses
  localparam logic [1:0] LFOC_RESP_OKAY = 2'h0;
  localparam logic [1:0] LFOC_RESP_SLVERR = 2'h2;

  function automatic logic [9:0] lfoc_idx(input logic [11:0] addr);
    return addr[11:2];
  endfunction

  function automatic logic lfoc_mapped(input logic [9:0] idx);
    return (idx >= LFOC_CTRL_IDX) && (idx <= LFOC_IMASK_IDX);
  endfunction
endpackage

//--- core/lfoc_osc_core.sv
// Oscillator model with trim, glitch-free divider and ready flag
`timescale 1ns/100ps
`default_nettype none
module lfoc_osc_core #(
  parameter logic [11:0] HALF_FAST = lfoc_pkg::LFOC_HALF_FAST,
  parameter logic [11:0] TRIM_STEP = 12'(lfoc_pkg::LFOC_TRIM_STEP),
  parameter logic [7:0] SETTLE_PER = lfoc_pkg::LFOC_SETTLE_PER
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Control
  input wire logic i_enable,
  input wire logic [3:0] i_trim,
  input wire logic [1:0] i_dsel,
  input wire logic i_dsel_chg,
  // Outputs
  output logic o_osc,
  output logic o_lfo_clk,
  output logic o_ready
);
  typedef struct packed {
    logic [11:0] cnt;
    logic osc;
    logic [2:0] div;
    logic [1:0] sel;
    logic [7:0] settle;
    logic ready;
    logic out;
  } lfoc_core_type;

  lfoc_core_type q;
  lfoc_core_type d;
  logic [11:0] half;
  logic rise;

  always_comb
  begin
    d = q;
    rise = 1'b0;
    // Larger trim code lengthens the half period: slower oscillator
    half = HALF_FAST + 12'(i_trim * TRIM_STEP); // R6 R1
    if (!i_enable)
    begin
      d.cnt = '0; // R3
      d.osc = 1'b0;
      d.div = '0;
      d.sel = i_dsel;
    end
    else if (q.cnt >= half - 12'h001)
    begin
      d.cnt = '0;
      d.osc = !q.osc;
      rise = !q.osc;
    end
    else
    begin
      d.cnt = q.cnt + 12'h001;
    end
    if (rise)
    begin
      d.div = q.div + 3'h1;
      // New ratio only at the wrap, so no runt pulse reaches the output
      if (d.div == 3'h0)
      begin
        d.sel = i_dsel; // R15
      end
      if (!q.ready && q.sel == i_dsel)
      begin
        d.settle = q.settle + 8'h01;
        if (q.settle == SETTLE_PER - 8'h01)
        begin
          d.ready = 1'b1; // R4
        end
      end
    end
    if (i_dsel_chg)
    begin
      d.ready = 1'b0; // R5
      d.settle = '0;
    end
    case (d.sel) // R2
      lfoc_pkg::LFOC_DIV1: d.out = d.osc;
      lfoc_pkg::LFOC_DIV2: d.out = d.div[0];
      lfoc_pkg::LFOC_DIV4: d.out = d.div[1];
      default: d.out = d.div[2];
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      q <= '0;
    else
      q <= d;
  end

  assign o_osc = q.osc;
  assign o_lfo_clk = q.out;
  assign o_ready = q.ready;
endmodule // lfoc_osc_core
`default_nettype wire

//--- core/lfoc_cap_timer.sv
// Free-running 16-bit timer that captures on one edge of the oscillator output
`timescale 1ns/100ps
`default_nettype none
module lfoc_cap_timer #(
  parameter bit RISE = 1'b0
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Capture control
  input wire logic i_mode,
  input wire logic i_lfo,
  // Results
  output logic [15:0] o_count,
  output logic [15:0] o_reload,
  output logic o_event
);
  typedef struct packed {
    logic [15:0] cnt;
    logic [15:0] reload;
    logic prev;
    logic ev;
  } lfoc_tmr_type;

  lfoc_tmr_type q;
  lfoc_tmr_type d;
  logic edge_seen;

  always_comb
  begin
    d = q;
    d.cnt = q.cnt + 16'h0001;
    d.prev = i_lfo;
    edge_seen = RISE ? (i_lfo && !q.prev) : (!i_lfo && q.prev); // R8
    d.ev = i_mode && edge_seen;
    if (d.ev)
    begin
      d.reload = q.cnt; // R9
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      q <= '0;
    else
      q <= d;
  end

  assign o_count = q.cnt;
  assign o_reload = q.reload;
  assign o_event = q.ev;
endmodule // lfoc_cap_timer
`default_nettype wire

//--- core/lfoc_top.sv
// Low-frequency oscillator control with AXI4-Lite registers and capture timers
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
// Contract
// (R1) Undivided oscillator runs at a nominal 80 kHz.
// (R2) Divider select 00,01,10,11 divides by 8,4,2,1.
// (R3) Oscillator runs only while enable bit 7 is one.
// (R4) Read-only ready in bit 6 shows one once stable.
// (R5) Ready clears only on reset or a divider select change.
// (R6) Trim 0000 is fastest, 1111 slowest.
// (R7) Trim in bits 5:2, divider select in 1:0, both read/write.
// (R8) Capture mode: timer A on falling, timer B on rising edges.
// (R9) Each capture copies the current count into the reload value.
// (R10) Software derives the period from two captures and retrims.
// (R11) Crystal mode claims both crystal pins.
// (R12) Capacitor, RC or CMOS mode claims only the crystal out pin.
// (R13) Software makes the crossbar skip claimed pins.
// (R14) Software sets claimed pins analog or digital input by mode.
// (R15) Ratio changes without runt; ready low while it settles.
module lfoc_top #(
  parameter logic [3:0] TRIM_RESET = lfoc_pkg::LFOC_TRIM_RST
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // AXI4-Lite write address
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [11:0] i_awaddr,
  // AXI4-Lite write data
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  // AXI4-Lite write response
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  // AXI4-Lite read
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [11:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  // Oscillator and pins
  output logic o_lfo_clk,
  output logic o_crystal_in_pin_claim,
  output logic o_crystal_out_pin_claim,
  // Interrupt
  output logic o_irq
);
  typedef struct packed {
    logic aw_ok;
    logic [9:0] aw_idx;
    logic w_ok;
    logic [7:0] w_byte;
    logic w_en;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic enable;
    logic [3:0] trim;
    logic [1:0] dsel;
    logic [2:0] ext_mode;
    logic [1:0] cap_mode;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic rdy_prev;
    logic [1:0] pin_claim;
    logic irq;
  } lfoc_regs_type;

  localparam lfoc_regs_type LFOC_RST = '{trim: TRIM_RESET, default: '0};

  lfoc_regs_type q;
  lfoc_regs_type d;
  logic dsel_chg;
  logic wr_go;
  logic [2:0] irq_set;
  logic [2:0] irq_clr;
  logic [9:0] ar_idx;
  logic lfo_osc;
  logic lfo_ready;
  logic [15:0] cnt_a;
  logic [15:0] cnt_b;
  logic [15:0] rel_a;
  logic [15:0] rel_b;
  logic ev_a;
  logic ev_b;

  lfoc_osc_core u_core (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_enable(q.enable),
    .i_trim(q.trim),
    .i_dsel(q.dsel),
    .i_dsel_chg(dsel_chg),
    .o_osc(lfo_osc),
    .o_lfo_clk(o_lfo_clk),
    .o_ready(lfo_ready)
  );

  lfoc_cap_timer #(.RISE(1'b0)) u_tmr_a (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_mode(q.cap_mode[0]),
    .i_lfo(o_lfo_clk),
    .o_count(cnt_a),
    .o_reload(rel_a),
    .o_event(ev_a)
  );

  lfoc_cap_timer #(.RISE(1'b1)) u_tmr_b (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_mode(q.cap_mode[1]),
    .i_lfo(o_lfo_clk),
    .o_count(cnt_b),
    .o_reload(rel_b),
    .o_event(ev_b)
  );

  // Handshake outputs stay low while a response is pending
  assign o_awready = !q.aw_ok && !q.bvalid;
  assign o_wready = !q.w_ok && !q.bvalid;
  assign o_arready = !q.rvalid;
  assign ar_idx = lfoc_pkg::lfoc_idx(i_araddr);

  always_comb
  begin
    d = q;
    dsel_chg = 1'b0;
    irq_clr = '0;
    wr_go = q.aw_ok && q.w_ok && !q.bvalid;
    if (i_awvalid && o_awready)
    begin
      d.aw_ok = 1'b1;
      d.aw_idx = lfoc_pkg::lfoc_idx(i_awaddr);
    end
    if (i_wvalid && o_wready)
    begin
      d.w_ok = 1'b1;
      d.w_byte = i_wdata[7:0];
      d.w_en = i_wstrb[0];
    end
    if (wr_go)
    begin
      d.aw_ok = 1'b0;
      d.w_ok = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = lfoc_pkg::lfoc_mapped(q.aw_idx) ?
        lfoc_pkg::LFOC_RESP_OKAY : lfoc_pkg::LFOC_RESP_SLVERR;
      if (q.w_en)
      begin
        case (q.aw_idx)
          lfoc_pkg::LFOC_CTRL_IDX:
          begin
            d.enable = q.w_byte[lfoc_pkg::LFOC_EN_BIT]; // R3
            d.trim = q.w_byte[lfoc_pkg::LFOC_TRIM_LSB +: 4]; // R7
            d.dsel = q.w_byte[lfoc_pkg::LFOC_DSEL_LSB +: 2]; // R7
            dsel_chg = d.dsel != q.dsel; // R5
          end
          lfoc_pkg::LFOC_EXT_IDX:
            d.ext_mode = q.w_byte[lfoc_pkg::LFOC_XMODE_LSB +: 3];
          lfoc_pkg::LFOC_TCFG_IDX:
            d.cap_mode = q.w_byte[1:0];
          lfoc_pkg::LFOC_ISTAT_IDX:
            irq_clr = q.w_byte[2:0];
          lfoc_pkg::LFOC_IMASK_IDX:
            d.irq_mask = q.w_byte[2:0];
          default:
            d.bvalid = 1'b1;
        endcase
      end
    end
    if (q.bvalid && i_bready)
    begin
      d.bvalid = 1'b0;
    end
    if (i_arvalid && o_arready)
    begin
      d.rvalid = 1'b1;
      d.rresp = lfoc_pkg::lfoc_mapped(ar_idx) ?
        lfoc_pkg::LFOC_RESP_OKAY : lfoc_pkg::LFOC_RESP_SLVERR;
      d.rdata = '0;
      case (ar_idx)
        lfoc_pkg::LFOC_CTRL_IDX:
        begin
          d.rdata[lfoc_pkg::LFOC_EN_BIT] = q.enable;
          d.rdata[lfoc_pkg::LFOC_RDY_BIT] = lfo_ready; // R4
          d.rdata[lfoc_pkg::LFOC_TRIM_LSB +: 4] = q.trim; // R7
          d.rdata[lfoc_pkg::LFOC_DSEL_LSB +: 2] = q.dsel; // R7
        end
        lfoc_pkg::LFOC_EXT_IDX:
          d.rdata[lfoc_pkg::LFOC_XMODE_LSB +: 3] = q.ext_mode;
        lfoc_pkg::LFOC_TCFG_IDX:
          d.rdata[1:0] = q.cap_mode;
        lfoc_pkg::LFOC_CAPA_IDX:
          d.rdata = {cnt_a, rel_a}; // R9
        lfoc_pkg::LFOC_CAPB_IDX:
          d.rdata = {cnt_b, rel_b}; // R9
        lfoc_pkg::LFOC_ISTAT_IDX:
          d.rdata[2:0] = q.irq_stat;
        lfoc_pkg::LFOC_IMASK_IDX:
          d.rdata[2:0] = q.irq_mask;
        default:
          d.rdata = '0;
      endcase
    end
    if (q.rvalid && i_rready)
    begin
      d.rvalid = 1'b0;
    end
    // A new event in the clearing cycle survives: set wins over clear
    d.rdy_prev = lfo_ready;
    irq_set = '0;
    irq_set[lfoc_pkg::LFOC_IRQ_CAPA] = ev_a;
    irq_set[lfoc_pkg::LFOC_IRQ_CAPB] = ev_b;
    irq_set[lfoc_pkg::LFOC_IRQ_RDY] = lfo_ready && !q.rdy_prev;
    d.irq_stat = (q.irq_stat & ~irq_clr) | irq_set;
    d.irq = |(d.irq_stat & d.irq_mask);
    // Pin claims follow the external oscillator mode
    d.pin_claim[0] = d.ext_mode[2:1] == lfoc_pkg::LFOC_XM_XTAL; // R11
    d.pin_claim[1] = d.ext_mode[2:1] != lfoc_pkg::LFOC_XM_OFF; // R11 R12
  end

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      q <= LFOC_RST;
    else
      q <= d;
  end

  assign o_bvalid = q.bvalid;
  assign o_bresp = q.bresp;
  assign o_rvalid = q.rvalid;
  assign o_rdata = q.rdata;
  assign o_rresp = q.rresp;
  assign o_crystal_in_pin_claim = q.pin_claim[0];
  assign o_crystal_out_pin_claim = q.pin_claim[1];
  assign o_irq = q.irq;

  default clocking lfoc_cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_n);

  chk_ready_clear: assert property (dsel_chg |=> !lfo_ready) // R5
    else $error("ready flag not cleared by divider change");

  chk_ready_hold: assert property (lfo_ready && !dsel_chg |=> lfo_ready) // R5
    else $error("ready flag dropped without divider change");

  chk_osc_stop: assert property (!q.enable |=> !lfo_osc && !o_lfo_clk) // R3
    else $error("oscillator running while disabled");

  chk_half_period: assert property ($rose(lfo_osc) |=> lfo_osc [*8]) // R1
    else $error("oscillator half period too short");

  chk_no_runt: assert property ($changed(o_lfo_clk) |=> $stable(o_lfo_clk) [*8]) // R15
    else $error("runt pulse on divided output");

  chk_div_one: assert property (
    q.enable && $stable(q.dsel) && q.dsel == lfoc_pkg::LFOC_DIV1 && $rose(lfo_osc)
    ##1 $stable(q.dsel) [*2] |-> o_lfo_clk == lfo_osc) // R2
    else $error("divide by one output differs from oscillator");

  chk_trim_write: assert property (
    wr_go && q.w_en && q.aw_idx == lfoc_pkg::LFOC_CTRL_IDX
    |=> q.trim == $past(q.w_byte[5:2]) && q.dsel == $past(q.w_byte[1:0])) // R7
    else $error("trim or divider field not stored");

  chk_ready_read: assert property (
    i_arvalid && o_arready && ar_idx == lfoc_pkg::LFOC_CTRL_IDX
    |=> o_rvalid && o_rdata[6] == $past(lfo_ready)) // R4
    else $error("ready bit read back wrong");

  chk_cap_edge: assert property (q.cap_mode[0] && $fell(o_lfo_clk) |=> ev_a) // R8
    else $error("falling edge capture missed");

  chk_cap_copy: assert property (ev_b |-> rel_b == $past(cnt_b)) // R9
    else $error("reload does not hold captured count");

  chk_pin_xtal: assert property (
    q.ext_mode[2:1] == lfoc_pkg::LFOC_XM_XTAL |-> o_crystal_in_pin_claim
    && o_crystal_out_pin_claim) // R11
    else $error("crystal mode did not claim both pins");

  chk_pin_single: assert property (
    q.ext_mode[2] ^ q.ext_mode[1] || q.ext_mode[2:1] == 2'h1
    |-> !o_crystal_in_pin_claim && o_crystal_out_pin_claim) // R12
    else $error("single pin mode claim wrong");

  cov_ready_set: cover property ($rose(lfo_ready));
  cov_capture_a: cover property (ev_a ##[1:1000] ev_a);
  cov_ratio_change: cover property (dsel_chg ##[1:1000] $rose(lfo_ready));
  cov_irq: cover property ($rose(o_irq));
endmodule // lfoc_top
`default_nettype wire

//--- test/low_freq_oscillator_control_bench.sv
// Self-checking bench for the low-frequency oscillator control block
`timescale 1ns/100ps
`default_nettype none
module low_freq_oscillator_control_bench;
  localparam logic [9:0] CT = lfoc_pkg::LFOC_CTRL_IDX;
  localparam logic [9:0] IS = lfoc_pkg::LFOC_ISTAT_IDX;
  localparam logic [9:0] IM = lfoc_pkg::LFOC_IMASK_IDX;
  localparam logic [1:0] OK = lfoc_pkg::LFOC_RESP_OKAY;
  localparam int LIMIT = 60000;
  logic i_mclk, i_rst_n, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic [11:0] i_awaddr, i_araddr;
  logic [31:0] i_wdata, o_rdata, rd;
  logic [3:0] i_wstrb;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_lfo_clk, o_irq;
  logic o_crystal_in_pin_claim, o_crystal_out_pin_claim;
  logic [1:0] o_bresp, o_rresp, rs;
  logic [15:0] a1, b1, a2;
  logic [3:0] t;
  int bad_count, samples_checked, half, cnt;

  lfoc_top lfoc_top_inst (.i_mclk, .i_rst_n, .i_awvalid, .o_awready, .i_awaddr, .i_wvalid,
    .o_wready, .i_wdata, .i_wstrb, .o_bvalid, .i_bready, .o_bresp, .i_arvalid, .o_arready,
    .i_araddr, .o_rvalid, .i_rready, .o_rdata, .o_rresp, .o_lfo_clk, .o_crystal_in_pin_claim,
    .o_crystal_out_pin_claim, .o_irq);

  initial
  begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic guard(inout int n);
    n++;
    if (n > LIMIT)
    begin
      bad_count++;
      $display("wrong value at %0t: wait ran out", $time);
      finish_test();
    end
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask

  // Ready is sampled on the falling edge; payload moves on the following rising edge
  task automatic axi_write(input logic [9:0] idx, input logic [7:0] d, output logic [1:0] r);
    logic aw, w, ta, tw, b;
    int n;
    aw = 1'b0;
    w = 1'b0;
    b = 1'b0;
    n = 0;
    @(posedge i_mclk);
    i_awvalid <= 1'b1;
    i_awaddr <= {idx, 2'h0};
    i_wvalid <= 1'b1;
    i_wdata <= {24'h0, d};
    i_bready <= 1'b1;
    while (!b)
    begin
      @(negedge i_mclk);
      ta = !aw && o_awready === 1'b1;
      tw = !w && o_wready === 1'b1;
      b = aw && w && o_bvalid === 1'b1;
      r = o_bresp;
      guard(n);
      @(posedge i_mclk);
      if (ta)
      begin
        aw = 1'b1;
        i_awvalid <= 1'b0;
      end
      if (tw)
      begin
        w = 1'b1;
        i_wvalid <= 1'b0;
      end
    end
    i_bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [9:0] idx, output logic [31:0] d, output logic [1:0] r);
    logic ar, ta, v;
    int n;
    ar = 1'b0;
    v = 1'b0;
    n = 0;
    @(posedge i_mclk);
    i_arvalid <= 1'b1;
    i_araddr <= {idx, 2'h0};
    i_rready <= 1'b1;
    while (!v)
    begin
      @(negedge i_mclk);
      ta = !ar && o_arready === 1'b1;
      v = ar && o_rvalid === 1'b1;
      d = o_rdata;
      r = o_rresp;
      guard(n);
      @(posedge i_mclk);
      if (ta)
      begin
        ar = 1'b1;
        i_arvalid <= 1'b0;
      end
    end
    i_rready <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    axi_write(idx, d, rs);
    check({30'h0, rs}, {30'h0, OK}, "write response");
  endtask

  task automatic rd_chk(input logic [9:0] idx, input logic [31:0] exp, input logic [1:0] er,
    input string what);
    axi_read(idx, rd, rs);
    check(rd, exp, what);
    check({30'h0, rs}, {30'h0, er}, what);
  endtask

  task automatic wait_lvl(input logic lvl);
    int n;
    n = 0;
    do
    begin
      @(negedge i_mclk);
      guard(n);
    end
    while (o_lfo_clk !== lvl);
  endtask

  // Counts the cycles of one whole high phase of the divided output
  task automatic high_len(output int c);
    wait_lvl(1'b0);
    wait_lvl(1'b1);
    c = 0;
    do
    begin
      @(negedge i_mclk);
      guard(c);
    end
    while (o_lfo_clk === 1'b1);
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    do
    begin
      axi_read(CT, rd, rs);
      guard(n);
    end
    while (rd[6] !== 1'b1);
  endtask

  task automatic cap_read(input logic lvl, input logic [9:0] idx, output logic [15:0] v);
    wait_lvl(!lvl);
    wait_lvl(lvl);
    repeat (4) @(negedge i_mclk);
    axi_read(idx, rd, rs);
    v = rd[15:0];
  endtask

  initial
  begin
    bad_count = 0;
    samples_checked = 0;
    half = int'(lfoc_pkg::LFOC_HALF_FAST);
    i_rst_n = 1'b0;
    i_awvalid = 1'b0;
    i_wvalid = 1'b0;
    i_bready = 1'b0;
    i_arvalid = 1'b0;
    i_rready = 1'b0;
    i_awaddr = 12'h000;
    i_araddr = 12'h000;
    i_wdata = 32'h0;
    i_wstrb = 4'h1;
    repeat (20) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    rd_chk(CT, {26'h0, lfoc_pkg::LFOC_TRIM_RST, 2'h0}, OK, "control reset");
    for (int i = 0; i < 4; i++)
      rd_chk(10'h0E4 + 10'(i < 2 ? i : i + 2), 32'h0, OK, "register reset");
    rd_chk(10'h0E2, 32'h0, lfoc_pkg::LFOC_RESP_SLVERR, "unmapped read");
    axi_write(10'h0EA, 8'hFF, rs);
    check({30'h0, rs}, {30'h0, lfoc_pkg::LFOC_RESP_SLVERR}, "unmapped write");
    check({31'h0, o_irq}, 32'h0, "irq after reset");
    $display("test reset done");
    for (int c = 0; c < 4; c++)
    begin
      wr(CT, {2'h0, 4'(c * 5), 2'(c)});
      rd_chk(CT, {26'h0, 4'(c * 5), 2'(c)}, OK, "field readback");
    end
    wr(CT, 8'hFF);
    rd_chk(CT, 32'hBF, OK, "ready not writable");
    $display("test fields done");
    wr(CT, 8'h83);
    wait_ready();
    for (int k = 0; k < 3; k++)
    begin
      t = 4'(k == 0 ? 0 : (k == 1 ? 8 : 15));
      wr(CT, {2'h2, t, 2'h3});
      rd_chk(CT, {26'h3, t, 2'h3}, OK, "ready kept on trim change");
      high_len(cnt);
      check(32'(cnt), 32'(half + int'(lfoc_pkg::LFOC_TRIM_STEP) * int'(t)), "half period");
    end
    $display("test trim done");
    wr(CT, 8'h83);
    wr(IM, 8'h03);
    wr(lfoc_pkg::LFOC_TCFG_IDX, 8'h03);
    cap_read(1'b0, lfoc_pkg::LFOC_CAPA_IDX, a1);
    cap_read(1'b1, lfoc_pkg::LFOC_CAPB_IDX, b1);
    cap_read(1'b0, lfoc_pkg::LFOC_CAPA_IDX, a2);
    check({16'h0, 16'(b1 - a1)}, 32'(half), "rise capture after fall");
    check({16'h0, 16'(a2 - a1)}, 32'(2 * half), "captured period");
    rd_chk(IS, 32'h7, OK, "capture status");
    repeat (2) @(negedge i_mclk);
    check({31'h0, o_irq}, 32'h1, "irq raised");
    wr(IM, 8'h00);
    repeat (2) @(negedge i_mclk);
    check({31'h0, o_irq}, 32'h0, "irq masked");
    wr(lfoc_pkg::LFOC_TCFG_IDX, 8'h00);
    wr(IS, 8'h07);
    rd_chk(IS, 32'h0, OK, "status cleared");
    $display("test capture done");
    // Straight to divide by eight keeps the run short; one settle covers both checks
    wr(CT, 8'h80);
    rd_chk(CT, 32'h80, OK, "ready cleared by divider change");
    wr(IM, 8'h04);
    wait_ready();
    repeat (2) @(negedge i_mclk);
    check({31'h0, o_irq}, 32'h1, "ready irq");
    high_len(cnt);
    check(32'(cnt), 32'(8 * half), "divide by eight");
    wr(CT, 8'h00);
    rd_chk(CT, 32'h40, OK, "ready kept on disable");
    cnt = 0;
    repeat (3000)
    begin
      @(negedge i_mclk);
      if (o_lfo_clk !== 1'b0)
        cnt++;
    end
    check(32'(cnt), 32'h0, "stopped output");
    $display("test divider and enable done");
    for (int m = 0; m < 8; m++)
    begin
      wr(lfoc_pkg::LFOC_EXT_IDX, 8'(m << 4));
      repeat (2) @(negedge i_mclk);
      check({31'h0, o_crystal_in_pin_claim}, {31'h0, m >= 6}, "in pin claim");
      check({31'h0, o_crystal_out_pin_claim}, {31'h0, m >= 2}, "out pin claim");
    end
    $display("test pins done");
    finish_test();
  end
endmodule // low_freq_oscillator_control_bench
`default_nettype wire
